// ==== design/gpr_cfg.svh ====
// Register offsets, field positions and reset values of the GPIO port register bank
`ifndef GPR_CFG_SVH
`define GPR_CFG_SVH
`define GPR_ADDR_W           5
`define GPR_OFF_MCU_CONTROL  5'h00
`define GPR_OFF_PORT_CONTROL 5'h01
`define GPR_OFF_LATCH_A      5'h02
`define GPR_OFF_DIR_A        5'h03
`define GPR_OFF_PIN_A        5'h04
`define GPR_OFF_LATCH_B      5'h05
`define GPR_OFF_DIR_B        5'h06
`define GPR_OFF_PIN_B        5'h07
`define GPR_OFF_LATCH_C      5'h08
`define GPR_OFF_DIR_C        5'h09
`define GPR_OFF_PIN_C        5'h0a
`define GPR_OFF_LATCH_D      5'h0b
`define GPR_OFF_DIR_D        5'h0c
`define GPR_OFF_PIN_D        5'h0d
`define GPR_OFF_ALT_D        5'h0e
`define GPR_MCU_WMASK        8'h70
`define GPR_MCU_PULLUP_OFF   4
`define GPR_OUTPUT_LATCH_A_MASK       8'h0f
`define GPR_RESET_BYTE       8'h00
`define GPR_ALT_PCE1_BIT     0
`define GPR_ALT_PCE2_BIT     1
`define GPR_ALT_IRQ0_BIT     2
`define GPR_ALT_IRQ1_BIT     3
`endif

// ==== design/gpr_pkg.sv ====
// Types shared by the GPIO port register bank
package gpr_pkg;
    typedef logic [7:0] gpr_byte_t;
    typedef enum logic [1:0] {
        GPR_BBM_IDLE = 2'b01,
        GPR_BBM_HOLD = 2'b10
    } gpr_bbm_state_t;
endpackage

// ==== design/gpr_port_bank.sv ====
// GPIO port register bank for ports A to D with alternate-function overrides of port D
// What this block does
// R01 - The pull-up, direction and output-value override enables of all port D pins stay 0.
// R02 - Input enable override of pins D7..D4 is mask bit AND group-2 enable, with value 1.
// R03 - Input enable override of D3..D0 is mask AND group enable, ORed with irq enable on D3, D2.
// R04 - The global pull-up off bit, bit 4 of the control register, turns off every pull-up.
// R05 - A port's break-before-make bit inserts one tri-state cycle when a pin turns to output; a pin turning during another pin's hold cycle gets none.
// R06 - Port-wise pull-up off bits 3..0 disable that port's pull-ups, ORed with the global bit.
// R07 - Port A implements bits 3..0 only; bits 7..4 of its registers read as 0.
// R08 - Pin-level registers are read-only and writes to them store nothing.
// R09 - Direction registers are read-write on all implemented bits and reset to 0.
// R10 - Output latch registers are read-write on all implemented bits and reset to 0.
// R11 - The MCU control register holds bits 6..4 read-write from reset 0, others read 0.
// R12 - Pin levels pass a two-flop synchroniser before software reads them.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "gpr_cfg.svh"
module gpr_port_bank (
    input  wire logic                    clk_in,
    input  wire logic                    reset_n_in,
    input  wire logic [`GPR_ADDR_W-1:0]  addr_in,
    input  wire logic [7:0]              wdata_in,
    input  wire logic                    wr_in,
    input  wire logic                    rd_in,
    output logic      [7:0]              rdata_out,
    input  wire logic [31:0]             pad_in,
    output logic      [31:0]             pad_out,
    output logic      [31:0]             pad_oe_n_out,
    output logic      [31:0]             pad_pullup_out,
    input  wire logic [7:0]              pin_change_mask_bit_in,
    output logic      [7:0]              pullup_override_en_out,
    output logic      [7:0]              direction_override_en_out,
    output logic      [7:0]              value_override_en_out,
    output logic      [7:0]              input_enable_override_en_out,
    output logic      [7:0]              input_enable_override_val_out
);
    typedef struct packed {
        gpr_pkg::gpr_byte_t mcu_control;
        gpr_pkg::gpr_byte_t port_control;
        logic [3:0][7:0]    latch;
        logic [3:0][7:0]    dir;
        gpr_pkg::gpr_byte_t alt_ctrl;
        gpr_pkg::gpr_byte_t rdata;
        gpr_pkg::gpr_byte_t die_en;
    } gpr_bank_t;
    gpr_bank_t  cur;
    gpr_bank_t  next_cur;
    logic [3:0][7:0] level;
    logic            global_pullup_off;

    assign global_pullup_off = cur.mcu_control[`GPR_MCU_PULLUP_OFF];

    // One pin block per port; port A upper bits stay unimplemented
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            logic [7:0] raw_level;
            gpr_port_pins u_pins (
                .clk_in         (clk_in),
                .reset_n_in     (reset_n_in),
                .latch_in       (cur.latch[p]),
                .dir_in         (cur.dir[p]),
                .pullup_off_in  (global_pullup_off | cur.port_control[p]), // see R06
                .bbm_en_in      (cur.port_control[p+4]),                   // see R05
                .pad_in         (pad_in[p*8 +: 8]),
                .pad_out        (pad_out[p*8 +: 8]),
                .pad_oe_n_out   (pad_oe_n_out[p*8 +: 8]),
                .pad_pullup_out (pad_pullup_out[p*8 +: 8]),
                .level_out      (raw_level)
            );
            assign level[p] = (p == 0) ? (raw_level & `GPR_OUTPUT_LATCH_A_MASK) : raw_level; // see R07
        end
    endgenerate

    // Register writes, read mux and port D input-enable overrides
    always_comb begin
        next_cur = cur;
        if (wr_in) begin
            case (addr_in)
                `GPR_OFF_MCU_CONTROL:  next_cur.mcu_control = wdata_in & `GPR_MCU_WMASK; // see R11
                `GPR_OFF_PORT_CONTROL: next_cur.port_control = wdata_in;
                `GPR_OFF_LATCH_A:      next_cur.latch[0] = wdata_in & `GPR_OUTPUT_LATCH_A_MASK; // see R07
                `GPR_OFF_DIR_A:        next_cur.dir[0] = wdata_in & `GPR_OUTPUT_LATCH_A_MASK;   // see R07
                `GPR_OFF_LATCH_B:      next_cur.latch[1] = wdata_in; // see R10
                `GPR_OFF_DIR_B:        next_cur.dir[1] = wdata_in;   // see R09
                `GPR_OFF_LATCH_C:      next_cur.latch[2] = wdata_in;
                `GPR_OFF_DIR_C:        next_cur.dir[2] = wdata_in;
                `GPR_OFF_LATCH_D:      next_cur.latch[3] = wdata_in;
                `GPR_OFF_DIR_D:        next_cur.dir[3] = wdata_in;
                `GPR_OFF_ALT_D:        next_cur.alt_ctrl = wdata_in & 8'h0f;
                // Pin-level offsets store nothing
                default:               next_cur.alt_ctrl = cur.alt_ctrl; // see R08
            endcase
        end
        // Read data stands only in the cycle after the strobe
        next_cur.rdata = `GPR_RESET_BYTE;
        if (rd_in) begin
            case (addr_in)
                `GPR_OFF_MCU_CONTROL:  next_cur.rdata = cur.mcu_control;
                `GPR_OFF_PORT_CONTROL: next_cur.rdata = cur.port_control;
                `GPR_OFF_LATCH_A:      next_cur.rdata = cur.latch[0];
                `GPR_OFF_DIR_A:        next_cur.rdata = cur.dir[0];
                `GPR_OFF_PIN_A:        next_cur.rdata = level[0]; // see R12
                `GPR_OFF_LATCH_B:      next_cur.rdata = cur.latch[1];
                `GPR_OFF_DIR_B:        next_cur.rdata = cur.dir[1];
                `GPR_OFF_PIN_B:        next_cur.rdata = level[1];
                `GPR_OFF_LATCH_C:      next_cur.rdata = cur.latch[2];
                `GPR_OFF_DIR_C:        next_cur.rdata = cur.dir[2];
                `GPR_OFF_PIN_C:        next_cur.rdata = level[2];
                `GPR_OFF_LATCH_D:      next_cur.rdata = cur.latch[3];
                `GPR_OFF_DIR_D:        next_cur.rdata = cur.dir[3];
                `GPR_OFF_PIN_D:        next_cur.rdata = level[3];
                `GPR_OFF_ALT_D:        next_cur.rdata = cur.alt_ctrl;
                default:               next_cur.rdata = `GPR_RESET_BYTE; // Unmapped reads 0
            endcase
        end
        // Upper pins: mask AND group-2 enable
        next_cur.die_en[7:4] = pin_change_mask_bit_in[7:4]
                             & {4{cur.alt_ctrl[`GPR_ALT_PCE2_BIT]}}; // see R02
        // Lower pins; bit 2 keeps the group-1 term exactly as printed
        next_cur.die_en[3] = cur.alt_ctrl[`GPR_ALT_IRQ1_BIT]
                           | (pin_change_mask_bit_in[3] & cur.alt_ctrl[`GPR_ALT_PCE2_BIT]); // see R03
        next_cur.die_en[2] = cur.alt_ctrl[`GPR_ALT_IRQ0_BIT]
                           | (pin_change_mask_bit_in[2] & cur.alt_ctrl[`GPR_ALT_PCE1_BIT]); // see R03
        next_cur.die_en[1:0] = pin_change_mask_bit_in[1:0]
                             & {2{cur.alt_ctrl[`GPR_ALT_PCE2_BIT]}}; // see R03
    end

    // State register, everything resets to 0
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cur <= '0; // see R09 see R10 see R11
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata_out                     = cur.rdata;
    // Alternate functions never take pull-up, direction or level
    assign pullup_override_en_out        = 8'h00; // see R01
    assign direction_override_en_out     = 8'h00; // see R01
    assign value_override_en_out         = 8'h00; // see R01
    assign input_enable_override_en_out  = cur.die_en;
    // Override value is constant 1 for every port D pin
    assign input_enable_override_val_out = 8'hff; // see R02 see R03
endmodule
`default_nettype wire

// ==== design/gpr_port_pins.sv ====
// One 8-pin port: synchroniser, pull-up and break-before-make pin drive
`timescale 1ns/1ps
`default_nettype none
`include "gpr_cfg.svh"
module gpr_port_pins (
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    input  wire logic [7:0]        latch_in,
    input  wire logic [7:0]        dir_in,
    input  wire logic              pullup_off_in,
    input  wire logic              bbm_en_in,
    input  wire logic [7:0]        pad_in,
    output logic      [7:0]        pad_out,
    output logic      [7:0]        pad_oe_n_out,
    output logic      [7:0]        pad_pullup_out,
    output logic      [7:0]        level_out
);
    typedef struct packed {
        gpr_pkg::gpr_byte_t sync1;
        gpr_pkg::gpr_byte_t sync2;
        gpr_pkg::gpr_byte_t dir_q;
        gpr_pkg::gpr_byte_t drv;
        gpr_pkg::gpr_byte_t oe_n;
        gpr_pkg::gpr_byte_t pu;
        gpr_pkg::gpr_bbm_state_t st;
    } gpr_pins_t;
    gpr_pins_t cur;
    gpr_pins_t next_cur;
    logic [7:0] rising;

    // Pins turning to output this cycle, used to hold them tri-stated once
    assign rising = dir_in & ~cur.dir_q;

    // Next state of the pin drivers
    always_comb begin
        next_cur = cur;
        next_cur.sync1 = pad_in;
        next_cur.sync2 = cur.sync1;          // see R12
        next_cur.dir_q = dir_in;
        next_cur.drv = latch_in;
        // Pull-up only on inputs with latch 1 and no disable active
        next_cur.pu = ~dir_in & latch_in & {8{~pullup_off_in}}; // see R04 see R06
        next_cur.oe_n = ~dir_in;
        next_cur.st = gpr_pkg::GPR_BBM_IDLE;
        case (cur.st)
            gpr_pkg::GPR_BBM_IDLE: begin
                if (bbm_en_in && (rising != 8'h00)) begin
                    // One extra tri-state cycle before the new driver starts
                    next_cur.oe_n = ~dir_in | rising; // see R05
                    next_cur.st = gpr_pkg::GPR_BBM_HOLD;
                end
            end
            gpr_pkg::GPR_BBM_HOLD: begin
                next_cur.st = gpr_pkg::GPR_BBM_IDLE;
            end
            default: begin
                next_cur.st = gpr_pkg::GPR_BBM_IDLE;
            end
        endcase
    end

    // State register; all pins come up as inputs
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cur <= '{sync1: 8'h00, sync2: 8'h00, dir_q: 8'h00, drv: 8'h00,
                     oe_n: 8'hff, pu: 8'h00, st: gpr_pkg::GPR_BBM_IDLE};
        end else begin
            cur <= next_cur;
        end
    end

    assign pad_out        = cur.drv;
    assign pad_oe_n_out   = cur.oe_n;
    assign pad_pullup_out = cur.pu;
    assign level_out      = cur.sync2;
endmodule
`default_nettype wire

// ==== verification/gpr_pin_model.sv ====
// Board-side model of the 32 port pins
`timescale 1ns/1ps
`default_nettype none
module gpr_pin_model (
    input  wire logic        clk_in,
    input  wire logic [31:0] pad_out_in,
    input  wire logic [31:0] oe_n_in,
    input  wire logic [31:0] pullup_in,
    input  wire logic [31:0] ext_en_in,
    input  wire logic [31:0] ext_val_in,
    output var  logic [31:0] level_out
);
    logic [31:0] float_q = 32'h0;
    // Undriven pins wander each cycle so a stale level never passes for a drive
    always_ff @(posedge clk_in) float_q <= ~float_q;
    // Device drive wins, then the board, then the pull-up
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (!oe_n_in[i]) level_out[i] = pad_out_in[i];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else level_out[i] = pullup_in[i] | float_q[i];
        end
    end
endmodule
`default_nettype wire

// ==== verification/gpr_port_bank_properties.sv ====
// Port-level checker for the GPIO port register bank
`timescale 1ns/1ps
`default_nettype none
`include "gpr_cfg.svh"
module gpr_port_bank_checker (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic [4:0]  addr_in,
    input wire logic [7:0]  wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [7:0]  rdata_out,
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe_n_out,
    input wire logic [31:0] pad_pullup_out,
    input wire logic [7:0]  pin_change_mask_bit_in,
    input wire logic [7:0]  pullup_override_en_out,
    input wire logic [7:0]  direction_override_en_out,
    input wire logic [7:0]  value_override_en_out,
    input wire logic [7:0]  input_enable_override_en_out,
    input wire logic [7:0]  input_enable_override_val_out
);
    logic [7:0] mcu_q, pctl_q;
    logic [3:0] alt_q;
    logic       dir_a0_q;
    // Shadow copies of the control registers, built from the write strobes alone
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            {mcu_q, pctl_q, alt_q, dir_a0_q} <= '0;
        end else if (wr_in) begin
            if (addr_in == `GPR_OFF_MCU_CONTROL) mcu_q <= wdata_in;
            if (addr_in == `GPR_OFF_PORT_CONTROL) pctl_q <= wdata_in;
            if (addr_in == `GPR_OFF_ALT_D) alt_q <= wdata_in[3:0];
            if (addr_in == `GPR_OFF_DIR_A) dir_a0_q <= wdata_in[0];
        end
    end
    // Expected input enables and per-port pull-up kill mask
    wire [7:0] m = pin_change_mask_bit_in;
    wire [7:0] die_exp = {m[7:4] & {4{alt_q[1]}}, m[3] & alt_q[1] | alt_q[3],
                          m[2] & alt_q[0] | alt_q[2], m[1:0] & {2{alt_q[1]}}};
    wire [31:0] pum = {{8{pctl_q[3]}}, {8{pctl_q[2]}}, {8{pctl_q[1]}}, {8{pctl_q[0]}}};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // A pin of port A turning to output, then its enable held off one extra cycle
    sequence s_turn_a0;
        wr_in && addr_in == `GPR_OFF_DIR_A && wdata_in[0] && !dir_a0_q;
    endsequence
    sequence s_held_a0;
        ##1 pad_oe_n_out[0] ##1 !pad_oe_n_out[0];
    endsequence
    a_override_zero: assert property ((pullup_override_en_out | direction_override_en_out
        | value_override_en_out) == 8'h00) else $error("override enable not zero");
    a_die_value: assert property (input_enable_override_val_out == 8'hff)
        else $error("input enable override value not one");
    a_die_upper: assert property (input_enable_override_en_out[7:4] == $past(die_exp[7:4]))
        else $error("upper input enable override wrong");
    a_die_lower: assert property (input_enable_override_en_out[3:0] == $past(die_exp[3:0]))
        else $error("lower input enable override wrong");
    a_global_pullup: assert property ($past(mcu_q[4]) |-> pad_pullup_out == 32'h0)
        else $error("pull-up on while globally off");
    a_port_pullup: assert property ((pad_pullup_out & $past(pum)) == 32'h0)
        else $error("pull-up on while port pull-up off");
    a_bbm_hold: assert property (s_turn_a0 ##0 pctl_q[4] |=> s_held_a0)
        else $error("break-before-make cycle missing");
    a_bbm_off: assert property (s_turn_a0 ##0 !pctl_q[4] |=> ##1 !pad_oe_n_out[0])
        else $error("output enable late without break-before-make");
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data outside read cycle");
    a_mcu_read: assert property (rd_in && addr_in == `GPR_OFF_MCU_CONTROL
        |=> rdata_out == ($past(mcu_q) & `GPR_MCU_WMASK)) else $error("mcu control read wrong");
    a_latch_drive: assert property (wr_in && addr_in == `GPR_OFF_LATCH_B
        |-> ##2 pad_out[15:8] == $past(wdata_in, 2)) else $error("latch not driven");
endmodule
bind gpr_port_bank gpr_port_bank_checker u_gpr_port_bank_checker (.clk_in, .reset_n_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .pad_out, .pad_oe_n_out, .pad_pullup_out,
    .pin_change_mask_bit_in, .pullup_override_en_out, .direction_override_en_out,
    .value_override_en_out, .input_enable_override_en_out, .input_enable_override_val_out);
`default_nettype wire

// ==== verification/gpr_port_bank_tb_top.sv ====
// Self-checking testbench for the GPIO port register bank
`timescale 1ns/1ps
`default_nettype none
module gpr_port_bank_tb_top;
    logic        clk_in, reset_n_in, wr_in, rd_in;
    logic [4:0]  addr_in;
    logic [7:0]  wdata_in, rdata_out, mask_in, pu_en, dd_en, pv_en, die_en, die_val;
    logic [31:0] pad_in, pad_out, pad_oe_n_out, pad_pullup_out, ext_en, ext_val;
    int          miscompares = 0;
    int          n_compared = 0;
    gpr_port_bank u_gpr_port_bank (.clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .pad_in, .pad_out, .pad_oe_n_out, .pad_pullup_out,
        .pin_change_mask_bit_in(mask_in), .pullup_override_en_out(pu_en),
        .direction_override_en_out(dd_en), .value_override_en_out(pv_en),
        .input_enable_override_en_out(die_en), .input_enable_override_val_out(die_val));
    gpr_pin_model u_gpr_pin_model (.clk_in, .pad_out_in(pad_out), .oe_n_in(pad_oe_n_out),
        .pullup_in(pad_pullup_out), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pad_in));
    // 40 MHz clock
    always #12.5 clk_in = ~clk_in;
    task automatic stop_test();
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus cycles: strobes last one cycle, read data is taken the cycle after
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        {addr_in, rd_in} <= {a, 1'b1};
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk({24'h0, rdata_out}, {24'h0, exp});
    endtask
    task automatic t_reset_values();
        logic [4:0] offs [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h09,
                                  5'h0b, 5'h0c, 5'h1f};
        foreach (offs[i]) rd(offs[i], 8'h00);
    endtask
    // Port A keeps only its low nibble; unmapped writes must vanish
    task automatic t_access();
        for (int p = 0; p < 4; p++) begin
            wr(5'(2 + 3 * p), 8'hff);
            wr(5'(3 + 3 * p), 8'hff);
            rd(5'(2 + 3 * p), p == 0 ? 8'h0f : 8'hff);
            rd(5'(3 + 3 * p), p == 0 ? 8'h0f : 8'hff);
        end
        wr(5'h00, 8'hff);
        rd(5'h00, 8'h70);
        wr(5'h00, 8'h00);
        wr(5'h1f, 8'hff);
        rd(5'h1f, 8'h00);
    endtask
    task automatic t_pins();
        wr(5'h05, 8'ha5);
        repeat (4) @(posedge clk_in);
        rd(5'h07, 8'ha5);
        wr(5'h07, 8'h5a);
        rd(5'h07, 8'ha5);
        rd(5'h04, 8'h0f);
        wr(5'h0c, 8'h00);
        repeat (4) @(posedge clk_in);
        ext_val[31:24] <= 8'h3c;
        rd(5'h0d, 8'h00);
        rd(5'h0d, 8'h3c);
    endtask
    // Port C pulled up, then killed port-wise and globally
    task automatic t_pullup();
        wr(5'h09, 8'h00);
        repeat (2) @(posedge clk_in);
        #1 chk({24'h0, pad_pullup_out[23:16]}, 32'hff);
        rd(5'h0a, 8'hff);
        wr(5'h01, 8'h04);
        rd(5'h01, 8'h04);
        repeat (2) @(posedge clk_in);
        #1 chk({24'h0, pad_pullup_out[23:16]}, 32'h00);
        wr(5'h01, 8'h00);
        wr(5'h00, 8'h10);
        repeat (2) @(posedge clk_in);
        #1 chk(pad_pullup_out, 32'h0);
        wr(5'h00, 8'h00);
    endtask
    task automatic t_bbm();
        wr(5'h01, 8'h10);
        wr(5'h03, 8'h00);
        wr(5'h03, 8'h01);
        // First edge after the direction lands: still tri-stated
        @(posedge clk_in);
        #1 chk({31'h0, pad_oe_n_out[0]}, 32'h1);
        @(posedge clk_in);
        #1 chk({31'h0, pad_oe_n_out[0]}, 32'h0);
        wr(5'h01, 8'h00);
        wr(5'h06, 8'h00);
        wr(5'h06, 8'h01);
        // Without the mode the driver turns on at that same first edge
        @(posedge clk_in);
        #1 chk({31'h0, pad_oe_n_out[8]}, 32'h0);
    endtask
    // Every enable combination against two complementary mask patterns
    task automatic t_override();
        logic [7:0] m;
        logic [3:0] a;
        logic [7:0] e;
        for (int k = 0; k < 32; k++) begin
            m = k[4] ? 8'h96 : 8'h69;
            a = k[3:0];
            e = {m[7:4] & {4{a[1]}}, m[3] & a[1] | a[3], m[2] & a[0] | a[2], m[1:0] & {2{a[1]}}};
            @(posedge clk_in);
            mask_in <= m;
            wr(5'h0e, {4'h0, a});
            repeat (2) @(posedge clk_in);
            #1 chk({24'h0, die_en}, {24'h0, e});
        end
        chk({pu_en, dd_en, pv_en, die_val}, 32'h000000ff);
        rd(5'h0e, 8'h0f);
    endtask
    // Reset in mid-run must bring every written register back to 0
    task automatic t_mid_reset();
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        @(posedge clk_in);
        #1 chk(pad_oe_n_out, 32'hffffffff);
        chk(pad_pullup_out, 32'h0);
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_reset_values();
    endtask
    initial begin
        {clk_in, reset_n_in, addr_in, wdata_in, wr_in, rd_in, mask_in, ext_val} = '0;
        ext_en = 32'hff000000;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_reset_values();
        t_access();
        t_pins();
        t_pullup();
        t_mid_reset();
        t_bbm();
        t_override();
        stop_test();
    end
    // A hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        stop_test();
    end
endmodule
`default_nettype wire
